// ==== design/srp_bus_if.sv ====
// Purpose: two-wire bus joining the device end and the host end
// Assumes: pull-ups on both lines
// Notes: works out the open-drain wire levels from the enables
interface srp_bus_if;
	logic scl_in;
	logic sda_in;
	logic host_scl_out;
	logic host_scl_oe;
	logic host_sda_out;
	logic host_sda_oe;
	logic dev_sda_out;
	logic dev_sda_oe;

	assign scl_in = !(host_scl_oe && !host_scl_out);
	assign sda_in = !((host_sda_oe && !host_sda_out) ||
		(dev_sda_oe && !dev_sda_out));

	modport device (
		input scl_in,
		input sda_in,
		output dev_sda_out,
		output dev_sda_oe
	);
	modport host (
		input scl_in,
		input sda_in,
		output host_scl_out,
		output host_scl_oe,
		output host_sda_out,
		output host_sda_oe
	);
endinterface : srp_bus_if

// ==== design/srp_device.sv ====
// Purpose: two-wire slave port to the encoder control registers
// Assumes: bus lines sampled on clk_i, far faster than the bus clock
// Notes: pointer and overflow flag survive a repeated start
module srp_device (
	input wire logic clk_i,
	input wire logic rst_n_i,
	srp_bus_if.device bus_if,
	input wire logic address_select_pin_i,
	output logic [7:0] mode_control_zero_o,
	output logic [31:0] subcarrier_freq_o,
	output logic busy_o
);
	import srp_pkg::*;

	// ************************************************************
	// line sampling and conditions
	// ************************************************************
	logic scl_q_ff;
	logic sda_q_ff;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic byte_done;
	logic slot_done;
	logic [6:0] own_addr;
	srp_dev_state_type state_ff;
	logic [3:0] bit_ff;
	logic [7:0] shift_ff;
	logic [7:0] tx_ff;
	logic [5:0] ptr_ff;
	logic over_ff;
	logic rw_ff;
	logic m_ack_ff;
	logic drive_low_ff;
	logic [5:0] nxt_ptr;
	logic nxt_over;
	logic wr_en;
	logic [7:0] regs_ff [REG_COUNT];

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			scl_q_ff <= 1'b1;
			sda_q_ff <= 1'b1;
		end
		else
		begin
			scl_q_ff <= bus_if.scl_in;
			sda_q_ff <= bus_if.sda_in;
		end
	end

	assign scl_rise = bus_if.scl_in && !scl_q_ff;
	assign scl_fall = !bus_if.scl_in && scl_q_ff;
	assign start_cond = bus_if.scl_in && scl_q_ff && sda_q_ff &&
		!bus_if.sda_in;
	assign stop_cond = bus_if.scl_in && scl_q_ff && !sda_q_ff &&
		bus_if.sda_in;
	assign byte_done = scl_fall && (bit_ff == ACK_SLOT);
	assign slot_done = scl_fall && (bit_ff == BYTE_END);
	assign own_addr = {DEV_ADDR_BASE[6:2], address_select_pin_i,
		DEV_ADDR_BASE[0]};

	// ************************************************************
	// pointer advance
	// ************************************************************
	// saturate at last
	assign nxt_ptr = (ptr_ff == REG_LAST) ? ptr_ff : ptr_ff + 6'h01;
	assign nxt_over = over_ff || (ptr_ff == REG_LAST);
	assign wr_en = byte_done && (state_ff == DS_WDATA) && !over_ff;

	// ************************************************************
	// byte engine
	// ************************************************************
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			state_ff <= DS_IDLE;
			bit_ff <= 4'h0;
			shift_ff <= 8'h00;
			tx_ff <= 8'h00;
			ptr_ff <= 6'h00;
			over_ff <= 1'b0;
			rw_ff <= 1'b0;
			m_ack_ff <= 1'b0;
			drive_low_ff <= 1'b0;
		end
		else if (start_cond)
		begin
			state_ff <= DS_ADDR;
			bit_ff <= 4'h0;
			drive_low_ff <= 1'b0;
		end
		else if (stop_cond)
		begin
			state_ff <= DS_IDLE;
			drive_low_ff <= 1'b0;
		end
		else if (state_ff != DS_IDLE)
		begin
			if (scl_rise)
			begin
				if (bit_ff < ACK_SLOT)
					shift_ff <= {shift_ff[6:0], bus_if.sda_in};
				else
					m_ack_ff <= !bus_if.sda_in;
				bit_ff <= bit_ff + 4'h1;
			end
			if (scl_fall && (state_ff == DS_RDATA) && (bit_ff != 4'h0) &&
				(bit_ff < ACK_SLOT))
				drive_low_ff <= !tx_ff[3'(4'h7 - bit_ff)];
			if (byte_done)
			begin
				case (state_ff)
					DS_ADDR:
					begin
						if (shift_ff[7:1] == own_addr)
						begin
							drive_low_ff <= 1'b1;
							rw_ff <= shift_ff[0];
						end
						else
							state_ff <= DS_IDLE;
					end
					DS_PTR:
					begin
						if (shift_ff[5:0] <= REG_LAST)
						begin
							drive_low_ff <= 1'b1;
							ptr_ff <= shift_ff[5:0];
							over_ff <= 1'b0;
						end
						else
							state_ff <= DS_IDLE;
					end
					DS_WDATA:
					begin
						if (over_ff)
							state_ff <= DS_IDLE;
						else
						begin
							drive_low_ff <= 1'b1;
							ptr_ff <= nxt_ptr;
							over_ff <= nxt_over;
						end
					end
					default:
						drive_low_ff <= 1'b0;
				endcase
			end
			if (slot_done)
			begin
				bit_ff <= 4'h0;
				case (state_ff)
					DS_ADDR:
					begin
						state_ff <= rw_ff ? DS_RDATA : DS_PTR;
						tx_ff <= regs_ff[ptr_ff];
						drive_low_ff <= rw_ff && !regs_ff[ptr_ff][7];
					end
					DS_RDATA:
					begin
						if (m_ack_ff)
						begin
							ptr_ff <= nxt_ptr;
							over_ff <= nxt_over;
							tx_ff <= regs_ff[nxt_ptr];
							drive_low_ff <= !regs_ff[nxt_ptr][7];
						end
						else
						begin
							state_ff <= DS_IDLE;
							drive_low_ff <= 1'b0;
						end
					end
					default:
					begin
						state_ff <= DS_WDATA;
						drive_low_ff <= 1'b0;
					end
				endcase
			end
		end
	end

	// ************************************************************
	// control registers
	// ************************************************************
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			for (int i = 0; i < REG_COUNT; i++)
				regs_ff[i] <= reg_default(6'(i));
		end
		else if (wr_en)
			regs_ff[ptr_ff] <= shift_ff;
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign bus_if.dev_sda_out = 1'b0;
	assign bus_if.dev_sda_oe = drive_low_ff;
	assign mode_control_zero_o = regs_ff[MODE0_IDX];
	assign subcarrier_freq_o = {regs_ff[FSC3_IDX], regs_ff[FSC2_IDX],
		regs_ff[FSC1_IDX], regs_ff[FSC0_IDX]};
	assign busy_o = (state_ff != DS_IDLE);
endmodule : srp_device

// ==== design/srp_host.sv ====
// Purpose: two-wire bus master driven over AXI4-Lite
// Assumes: one write or one read of one register per command
// Notes: bus clock made by dividing clk_i
//
// Register access over AXI4-Lite is this design's own decision.
module srp_host (
	input wire logic clk_i,
	input wire logic rst_n_i,
	srp_bus_if.host bus_if,
	input wire logic [3:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [3:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i
);
	import srp_pkg::*;

	typedef struct packed {
		srp_op_type op;
		logic [7:0] tx;
		logic rx;
	} srp_plan_type;

	function automatic logic addr_mapped(input logic [3:0] a);
		return (a == CMD_OFS) || (a == STAT_OFS) || (a == TGT_OFS);
	endfunction : addr_mapped

	logic aw_got_ff;
	logic w_got_ff;
	logic [3:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic do_write;
	logic start_cmd;
	logic [6:0] tgt_ff;
	logic [7:0] ptr_ff;
	logic [7:0] dat_ff;
	logic rd_ff;
	logic busy_ff;
	logic nack_ff;
	logic [7:0] rx_ff;
	logic [7:0] result_ff;
	logic [2:0] step_ff;
	logic [3:0] bit_ff;
	logic [1:0] qtr_ff;
	logic [8:0] tick_ff;
	logic qtick;
	logic scl_lvl_ff;
	logic sda_lvl_ff;
	logic scl_lvl;
	logic sda_lvl;
	srp_plan_type plan;

	// ************************************************************
	// AXI4-Lite slave
	// ************************************************************
	assign s_axi_awready_o = !aw_got_ff && !bvalid_ff;
	assign s_axi_wready_o = !w_got_ff && !bvalid_ff;
	assign s_axi_arready_o = !rvalid_ff;
	assign do_write = aw_got_ff && w_got_ff && !bvalid_ff;
	assign start_cmd = do_write && (awaddr_ff == CMD_OFS) && !busy_ff &&
		(wstrb_ff[2:0] == 3'h7);

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			awaddr_ff <= 4'h0;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
			tgt_ff <= 7'h00;
		end
		else
		begin
			if (s_axi_awvalid_i && s_axi_awready_o)
			begin
				aw_got_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o)
			begin
				w_got_ff <= 1'b1;
				wdata_ff <= s_axi_wdata_i;
				wstrb_ff <= s_axi_wstrb_i;
			end
			if (do_write)
			begin
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= addr_mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
				if ((awaddr_ff == TGT_OFS) && wstrb_ff[0])
					tgt_ff <= wdata_ff[6:0];
			end
			else if (bvalid_ff && s_axi_bready_i)
				bvalid_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= RESP_OKAY;
		end
		else if (s_axi_arvalid_i && s_axi_arready_o)
		begin
			rvalid_ff <= 1'b1;
			rresp_ff <= addr_mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
			if (s_axi_araddr_i == STAT_OFS)
				rdata_ff <= {16'h0000, result_ff, 6'h00, nack_ff, busy_ff};
			else if (s_axi_araddr_i == TGT_OFS)
				rdata_ff <= {25'h0000000, tgt_ff};
			else
				rdata_ff <= 32'h00000000;
		end
		else if (rvalid_ff && s_axi_rready_i)
			rvalid_ff <= 1'b0;
	end

	assign s_axi_bvalid_o = bvalid_ff;
	assign s_axi_bresp_o = bresp_ff;
	assign s_axi_rvalid_o = rvalid_ff;
	assign s_axi_rdata_o = rdata_ff;
	assign s_axi_rresp_o = rresp_ff;

	// ************************************************************
	// transfer plan and line levels
	// ************************************************************
	always_comb
	begin
		plan = '{op: OP_DONE, tx: 8'h00, rx: 1'b0};
		case (step_ff)
			3'h0: plan.op = OP_START;
			3'h1: plan = '{op: OP_BYTE, tx: {tgt_ff, 1'b0}, rx: 1'b0};
			3'h2: plan = '{op: OP_BYTE, tx: {2'h0, ptr_ff[5:0]}, rx: 1'b0};
			3'h3:
				if (rd_ff)
					plan.op = OP_START;
				else
					plan = '{op: OP_BYTE, tx: dat_ff, rx: 1'b0};
			3'h4:
				if (rd_ff)
					plan = '{op: OP_BYTE, tx: {tgt_ff, 1'b1}, rx: 1'b0};
				else
					plan.op = OP_STOP;
			3'h5:
				if (rd_ff)
					plan = '{op: OP_BYTE, tx: 8'h00, rx: 1'b1};
			3'h6:
				if (rd_ff)
					plan.op = OP_STOP;
			default: plan.op = OP_DONE;
		endcase
		scl_lvl = 1'b1;
		sda_lvl = 1'b1;
		case (plan.op)
			OP_START:
			begin
				scl_lvl = (qtr_ff == 2'h1) || (qtr_ff == 2'h2);
				sda_lvl = (qtr_ff < 2'h2);
			end
			OP_STOP:
			begin
				scl_lvl = (qtr_ff != 2'h0);
				sda_lvl = (qtr_ff >= 2'h2);
			end
			OP_BYTE:
			begin
				scl_lvl = (qtr_ff == 2'h1) || (qtr_ff == 2'h2);
				sda_lvl = (bit_ff < ACK_SLOT && !plan.rx) ?
					plan.tx[3'(4'h7 - bit_ff)] : 1'b1;
			end
			default:
			begin
				scl_lvl = 1'b1;
				sda_lvl = 1'b1;
			end
		endcase
	end

	// ************************************************************
	// bit sequencer
	// ************************************************************
	assign qtick = busy_ff && (tick_ff == QUARTER_CYC - 9'h001);

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			busy_ff <= 1'b0;
			nack_ff <= 1'b0;
			step_ff <= STEP_IDLE;
			bit_ff <= 4'h0;
			qtr_ff <= 2'h0;
			tick_ff <= 9'h000;
			rx_ff <= 8'h00;
			result_ff <= 8'h00;
			ptr_ff <= 8'h00;
			dat_ff <= 8'h00;
			rd_ff <= 1'b0;
			scl_lvl_ff <= 1'b1;
			sda_lvl_ff <= 1'b1;
		end
		else
		begin
			scl_lvl_ff <= scl_lvl;
			sda_lvl_ff <= sda_lvl;
			if (start_cmd)
			begin
				busy_ff <= 1'b1;
				nack_ff <= 1'b0;
				step_ff <= 3'h0;
				bit_ff <= 4'h0;
				qtr_ff <= 2'h0;
				tick_ff <= 9'h000;
				ptr_ff <= wdata_ff[7:0];
				dat_ff <= wdata_ff[15:8];
				rd_ff <= wdata_ff[CMD_RW_BIT];
			end
			else if (busy_ff && (plan.op == OP_DONE))
			begin
				busy_ff <= 1'b0;
				result_ff <= rx_ff;
			end
			else if (busy_ff)
			begin
				tick_ff <= qtick ? 9'h000 : tick_ff + 9'h001;
				if (qtick)
				begin
					qtr_ff <= qtr_ff + 2'h1;
					if ((qtr_ff == 2'h2) && (plan.op == OP_BYTE))
					begin
						if (bit_ff < ACK_SLOT)
							rx_ff <= {rx_ff[6:0], bus_if.sda_in};
						else if (!plan.rx && bus_if.sda_in)
							nack_ff <= 1'b1;
					end
					if (qtr_ff == 2'h3)
					begin
						if ((plan.op == OP_BYTE) && (bit_ff < ACK_SLOT))
							bit_ff <= bit_ff + 4'h1;
						else
						begin
							bit_ff <= 4'h0;
							if ((plan.op == OP_BYTE) && !plan.rx && nack_ff)
								step_ff <= rd_ff ? STEP_STOP_RD : STEP_STOP_WR;
							else
								step_ff <= step_ff + 3'h1;
						end
					end
				end
			end
		end
	end

	assign bus_if.host_scl_out = 1'b0;
	assign bus_if.host_scl_oe = !scl_lvl_ff;
	assign bus_if.host_sda_out = 1'b0;
	assign bus_if.host_sda_oe = !sda_lvl_ff;
endmodule : srp_host

// ==== design/srp_pkg.sv ====
// Purpose: shared constants and types of the serial register port
// Assumes: one clock, synchronous active-low reset
// Notes: used by the device end, the host end, the assertions and the bench
package srp_pkg;
	// ************************************************************
	// device register file
	// ************************************************************
	localparam int REG_COUNT = 36;
	localparam logic [5:0] REG_LAST = 6'h23;
	localparam logic [5:0] MODE0_IDX = 6'h00;
	localparam logic [5:0] FSC0_IDX = 6'h02;
	localparam logic [5:0] FSC1_IDX = 6'h03;
	localparam logic [5:0] FSC2_IDX = 6'h04;
	localparam logic [5:0] FSC3_IDX = 6'h05;
	localparam logic [7:0] MODE0_RST = 8'h04;
	localparam logic [7:0] FSC0_RST = 8'h16;
	localparam logic [7:0] FSC1_RST = 8'h7C;
	localparam logic [7:0] FSC2_RST = 8'hF0;
	localparam logic [7:0] FSC3_RST = 8'h21;
	localparam logic [7:0] OTHER_RST = 8'h00;
	// slave address, value arbitrary; bit 1 comes from a pin
	localparam logic [6:0] DEV_ADDR_BASE = 7'h28;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [3:0] BYTE_END = 4'h9;
	// ************************************************************
	// host register map and fields
	// ************************************************************
	localparam logic [3:0] CMD_OFS = 4'h0;
	localparam logic [3:0] STAT_OFS = 4'h4;
	localparam logic [3:0] TGT_OFS = 4'h8;
	localparam int CMD_RW_BIT = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [2:0] STEP_STOP_WR = 3'h4;
	localparam logic [2:0] STEP_STOP_RD = 3'h6;
	localparam logic [2:0] STEP_IDLE = 3'h7;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 8;
	localparam int QUARTER_NS = 625;
	localparam logic [8:0] QUARTER_CYC =
		9'((QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [2:0] {DS_IDLE, DS_ADDR, DS_PTR, DS_WDATA, DS_RDATA}
		srp_dev_state_type;
	typedef enum logic [1:0] {OP_START, OP_BYTE, OP_STOP, OP_DONE}
		srp_op_type;

	function automatic logic [7:0] reg_default(input logic [5:0] idx);
		logic [7:0] val;
		val = OTHER_RST;
		if (idx == MODE0_IDX)
			val = MODE0_RST;
		else if (idx == FSC0_IDX)
			val = FSC0_RST;
		else if (idx == FSC1_IDX)
			val = FSC1_RST;
		else if (idx == FSC2_IDX)
			val = FSC2_RST;
		else if (idx == FSC3_IDX)
			val = FSC3_RST;
		return val;
	endfunction : reg_default
endpackage : srp_pkg

// ==== test/srp_assertions.sv ====
// Purpose: protocol checks on the two-wire link between both ends
// Assumes: lines sampled on clk_i, open-drain levels already resolved
// Notes: instantiated beside the bus interface, no bind
module srp_assertions (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic dev_sda_oe,
	input wire logic address_select_pin_i
);
	timeunit 1ns;
	timeprecision 1ns;
	import srp_pkg::*;
	// ************************************************
	// link decode
	// ************************************************
	logic scl_q_ff, sda_q_ff, mute_ff, cond_ff;
	logic [4:0] cnt_ff;
	logic [7:0] addr_ff, ptr_ff;
	logic start_ev, stop_ev, rise, match, ptr_ack;

	assign start_ev = scl_in && scl_q_ff && sda_q_ff && !sda_in;
	assign stop_ev = scl_in && scl_q_ff && !sda_q_ff && sda_in;
	assign rise = scl_in && !scl_q_ff;
	assign match = addr_ff[7:1] ==
		(DEV_ADDR_BASE | {5'h00, address_select_pin_i, 1'b0});
	assign ptr_ack = rise && cnt_ff == 5'h11 && match && !addr_ff[0];

	always_ff @(posedge clk_i)
	begin
		scl_q_ff <= scl_in;
		sda_q_ff <= sda_in;
	end
	// clock rises since the last start, saturating
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			cnt_ff <= 5'h1F;
		else if (start_ev)
			cnt_ff <= 5'h00;
		else if (rise && cnt_ff != 5'h1F)
			cnt_ff <= cnt_ff + 5'h01;
	end
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			addr_ff <= 8'h00;
			ptr_ff <= 8'h00;
		end
		else if (rise && cnt_ff < 5'h08)
			addr_ff <= {addr_ff[6:0], sda_in};
		else if (rise && cnt_ff > 5'h08 && cnt_ff < 5'h11)
			ptr_ff <= {ptr_ff[6:0], sda_in};
	end
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i || start_ev)
			mute_ff <= 1'b0;
		else if (rise && cnt_ff == 5'h08 && !match)
			mute_ff <= 1'b1;
	end
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i || !scl_in)
			cond_ff <= 1'b0;
		else if (start_ev)
			cond_ff <= 1'b1;
	end
	// ************************************************
	// properties
	// ************************************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	AST_ADDR_LISTEN: assert property (
		(scl_in && scl_q_ff && cnt_ff > 5'h00 && cnt_ff < 5'h09) |-> !dev_sda_oe)
		else $error("device drove data during the address byte");
	AST_ACK_MATCH: assert property (
		(rise && cnt_ff == 5'h08 && match) |-> dev_sda_oe)
		else $error("own address not acknowledged");
	AST_NACK_OTHER: assert property (
		(rise && cnt_ff == 5'h08 && !match) |-> !dev_sda_oe)
		else $error("foreign address acknowledged");
	AST_STAY_IDLE: assert property (
		mute_ff |-> !dev_sda_oe)
		else $error("device drove data while idle");
	AST_PTR_ACK: assert property (
		(ptr_ack && ptr_ff[5:0] <= REG_LAST) |-> dev_sda_oe)
		else $error("valid pointer byte not acknowledged");
	AST_PTR_TOP: assert property (
		ptr_ack |-> (ptr_ff[7:6] == 2'h0))
		else $error("pointer byte top bits not zero");
	AST_PTR_BAD: assert property (
		(ptr_ack && ptr_ff[5:0] > REG_LAST) |-> !dev_sda_oe)
		else $error("invalid pointer byte acknowledged");
	AST_START_FREE: assert property (
		start_ev |-> ##[1:2] !dev_sda_oe)
		else $error("data line held after start");
	AST_STOP_FREE: assert property (
		stop_ev |-> ##[1:2] !dev_sda_oe)
		else $error("data line held after stop");
	AST_DRIVE_LOW: assert property (
		$rose(dev_sda_oe) |-> (!scl_in && !scl_q_ff))
		else $error("device took the data line with clock high");
	AST_DRIVE_HOLD: assert property (
		(scl_in && scl_q_ff && $past(dev_sda_oe)) |-> dev_sda_oe)
		else $error("device let go of data with clock high");
	AST_ONE_COND: assert property (
		(cond_ff && scl_in) |-> !(start_ev || stop_ev))
		else $error("second condition in one clock high period");
endmodule : srp_assertions

// ==== test/tb_top.sv ====
// Purpose: bench joining host and device ends over the two-wire link
// Assumes: full-length bus timing, roughly 53k cycles in all
// Notes: host registers from a table, then link transfers and reset
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import srp_pkg::*;
	typedef struct {
		logic wr;
		logic [3:0] addr;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic [1:0] resp;
	} srp_row_type;
	localparam int TIMEOUT_CYC = 60000;
	logic clk_i, rst_n_i, pin, dev_busy;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [3:0] awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata, st, d, fsc;
	logic [1:0] bresp, rresp, r;
	logic [7:0] mode0;
	int errors, n_tests;
	int cycles = 0;
	srp_row_type rows [7];

	srp_bus_if u_srp_bus_if ();
	srp_device u_srp_device (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.bus_if(u_srp_bus_if), .address_select_pin_i(pin),
		.mode_control_zero_o(mode0), .subcarrier_freq_o(fsc),
		.busy_o(dev_busy));
	srp_host u_srp_host (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.bus_if(u_srp_bus_if), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
		.s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
		.s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
	srp_assertions u_srp_assertions (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.scl_in(u_srp_bus_if.scl_in), .sda_in(u_srp_bus_if.sda_in),
		.dev_sda_oe(u_srp_bus_if.dev_sda_oe),
		.address_select_pin_i(pin));
	// ************************************************
	// tasks
	// ************************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			errors++;
			$display("Error %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic end_sim;
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
		logic done;
		@(posedge clk_i);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= v;
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		bready <= 1'b1;
		done = 1'b0;
		while (!done)
		begin
			@(posedge clk_i);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid && bready)
			begin
				r = bresp;
				bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : axi_wr
	task automatic axi_rd(input logic [3:0] a, output logic [31:0] v);
		logic done;
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		done = 1'b0;
		v = 32'h00000000;
		while (!done)
		begin
			@(posedge clk_i);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid && rready)
			begin
				v = rdata;
				r = rresp;
				rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : axi_rd
	task automatic dflt;
		@(negedge clk_i);
		chk(32'(mode0), 32'h04);
		chk(fsc, 32'h21F07C16);
		chk(32'(dev_busy), 32'h0);
	endtask : dflt
	task automatic xfer(input logic [31:0] cmd);
		axi_wr(CMD_OFS, cmd);
		chk(32'(r), 32'h0);
		wait (dev_busy === 1'b1);
		st = 32'h1;
		while (st[0] !== 1'b0)
			axi_rd(STAT_OFS, st);
	endtask : xfer
	// ************************************************
	// sequence
	// ************************************************
	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == TIMEOUT_CYC)
		begin
			errors++;
			$display("Error %0t: run did not finish", $time);
			end_sim();
		end
	end
	initial
	begin
		errors = 0;
		n_tests = 0;
		rst_n_i = 1'b0;
		pin = 1'b1;
		{awaddr, araddr, wstrb, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		rows = '{'{1'b0, TGT_OFS, 32'h0, 32'h0, RESP_OKAY},
			'{1'b1, TGT_OFS, 32'h2A, 32'h0, RESP_OKAY},
			'{1'b0, TGT_OFS, 32'h0, 32'h2A, RESP_OKAY},
			'{1'b1, STAT_OFS, 32'hFFFF, 32'h0, RESP_OKAY},
			'{1'b0, 4'hC, 32'h0, 32'h0, RESP_SLVERR},
			'{1'b1, 4'hC, 32'h1, 32'h0, RESP_SLVERR},
			'{1'b0, TGT_OFS, 32'h0, 32'h2A, RESP_OKAY}};
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		dflt();
		foreach (rows[i])
		begin
			if (rows[i].wr)
				axi_wr(rows[i].addr, rows[i].wdata);
			else
				axi_rd(rows[i].addr, d);
			if (!rows[i].wr)
				chk(d, rows[i].rdata);
			chk(32'(r), 32'(rows[i].resp));
		end
		xfer({15'h0000, 1'b0, 8'hA5, 8'h00});
		chk(32'(st[1]), 32'h0);
		chk(32'(mode0), 32'hA5);
		chk(fsc, 32'h21F07C16);
		xfer({15'h0000, 1'b1, 8'h00, 8'h00});
		chk(32'(st[15:8]), 32'hA5);
		chk(32'(st[1]), 32'h0);
		xfer({15'h0000, 1'b0, 8'h3C, 8'h24});
		chk(32'(st[1]), 32'h1);
		chk(32'(mode0), 32'hA5);
		xfer({15'h0000, 1'b0, 8'h77, 8'hC1});
		chk(32'(st[1]), 32'h0);
		xfer({15'h0000, 1'b1, 8'h00, 8'h01});
		chk(32'(st[15:8]), 32'h77);
		chk(32'(st[1]), 32'h0);
		@(posedge clk_i);
		pin <= 1'b0;
		xfer({15'h0000, 1'b0, 8'h5A, 8'h00});
		chk(32'(st[1]), 32'h1);
		chk(32'(mode0), 32'hA5);
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		dflt();
		end_sim();
	end
endmodule : tb_top
